// ### rtl/lsif_defines.vh
// constants for the light sensor interrupt flag block
`ifndef LSIF_DEFINES_VH
`define LSIF_DEFINES_VH

// register byte offsets on the axi4-lite bus
`define LSIF_ADDR_RESULT 4'h0
`define LSIF_ADDR_CONFIG 4'h4
`define LSIF_ADDR_LOW_LIMIT 4'h8
`define LSIF_ADDR_HIGH_LIMIT 4'hc

// configuration register fields
`define LSIF_CFG_MODE_HI 10
`define LSIF_CFG_MODE_LO 9
`define LSIF_CFG_READY_BIT 7
`define LSIF_CFG_OVER_BIT 6
`define LSIF_CFG_UNDER_BIT 5
`define LSIF_CFG_LATCH_BIT 4
`define LSIF_CFG_SENSE_BIT 3
`define LSIF_CFG_FC_HI 1
`define LSIF_CFG_FC_LO 0

// writable bits of the configuration register
`define LSIF_CFG_WMASK 16'h061b
`define LSIF_CFG_RESET 16'h0010
`define LSIF_LOW_RESET 16'h0000
`define LSIF_HIGH_RESET 16'hbfff

// shutdown code of the conversion-type field
`define LSIF_MODE_SHUTDOWN 2'h0
// low-limit top bits that select end-of-conversion indication
`define LSIF_EOC_CODE 2'h3

// axi responses
`define LSIF_RESP_OKAY 2'h0
`define LSIF_RESP_SLVERR 2'h2

`endif

// ### rtl/lsif_fault_counter.v
// consecutive-conversion fault counter for one limit comparison
`timescale 1ns/1ps
`default_nettype none

module lsif_fault_counter #(
  parameter CNT_W = 4
) (
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // conversion events
  input wire conv_done_i,
  input wire cond_i,
  input wire [1:0] fault_count_i,
  // fault strobe, same cycle as conv_done_i
  output wire fault_o
);

  reg [CNT_W-1:0] count_q;
  reg [CNT_W-1:0] count_d;
  wire [CNT_W-1:0] target;
  wire [CNT_W-1:0] next_count;

  // fault count codes 0..3 mean 1, 2, 4 and 8 consecutive conversions
  assign target = {{(CNT_W-1){1'b0}}, 1'b1} << fault_count_i;
  assign next_count = count_q + {{(CNT_W-1){1'b0}}, 1'b1};

  always @* begin
    count_d = count_q;
    if (conv_done_i) begin
      if (!cond_i) begin
        count_d = {CNT_W{1'b0}};
      end else if (count_q < target) begin
        count_d = next_count;
      end
    end
  end

  // saturates at the target so every further hit also faults
  // fault at programmed count
  assign fault_o = conv_done_i & cond_i & (count_d >= target);

  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      count_q <= {CNT_W{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end

endmodule // lsif_fault_counter

`default_nettype wire

// ### rtl/lsif_top.v
// interrupt flag logic of an ambient light sensor with axi4-lite registers
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lsif_defines.vh"

// Summary of operation
// - transparent mode, a high fault sequence sets over flag, clears under flag, activates irq.
// - transparent mode, a low fault sequence sets under flag, clears over flag, deactivates irq.
// - transparent mode, config reads and writes leave irq and both flags as they are.
// - with latch bit 0 the alert response is not acknowledged and changes nothing.
// - every conversion completion sets conversion-ready; flags hold without a fault.
// - a config read clears conversion-ready, as does a non-shutdown config write.
// - a shutdown config write leaves flags, irq and conversion-ready unchanged.
// - low-limit top two bits both one select end-of-conversion indication.
// - in end-of-conversion indication every completion activates the irq.
// - end-of-conversion latched, a config read or won alert clears irq; a read clears flags.
// - end-of-conversion latched, a high fault sets over flag, a low fault sets under flag.
// - end-of-conversion transparent, flags as transparent, irq cleared by read or write.
// - the pin is low when active with sense 0, low when inactive with sense 1, else high.
// - conversion-ready is cleared at once by a config read, so a second read sees 0.
// - config bit 4 selects latched window (1) or transparent hysteresis (0) comparison.
module lsif_top #(
  parameter CNT_W = 4
) (
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // axi4-lite write address
  input wire [3:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // axi4-lite read address
  input wire [3:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // conversion engine, same clock
  input wire conv_done_i,
  input wire [15:0] conv_result_i,
  // alert response from the serial framing, same clock
  input wire alert_req_i,
  input wire alert_won_i,
  output wire alert_ack_o,
  output wire alert_over_flag_o,
  // interrupt pin level
  output wire int_pin_o
);

  // exponent/mantissa word to a linear magnitude, used for both limits
  function [26:0] to_linear;
    input [15:0] word;
    begin
      to_linear = {15'h0000, word[11:0]} << word[15:12];
    end
  endfunction

  // ---------------- register state ----------------
  reg [15:0] cfg_q;
  reg [15:0] cfg_d;
  reg [15:0] low_q;
  reg [15:0] low_d;
  reg [15:0] high_q;
  reg [15:0] high_d;
  reg [15:0] result_q;
  reg over_q;
  reg over_d;
  reg under_q;
  reg under_d;
  reg ready_q;
  reg ready_d;
  reg active_q;
  reg active_d;
  reg int_pin_q;
  reg alert_ack_q;
  reg alert_over_q;

  // ---------------- axi state ----------------
  reg aw_held_q;
  reg [3:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  wire aw_fire;
  wire w_fire;
  wire ar_fire;
  wire wr_go;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [15:0] wr_mask;
  wire wr_mapped;
  wire rd_mapped;

  assign s_axi_awready_o = !aw_held_q && !bvalid_q;
  assign s_axi_wready_o = !w_held_q && !bvalid_q;
  assign s_axi_arready_o = !rvalid_q;
  assign aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  assign w_fire = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;

  // address and data may arrive in either order; the write happens once both are in
  assign wr_go = (aw_held_q || aw_fire) && (w_held_q || w_fire) && !bvalid_q;
  assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr_i;
  assign wr_data = w_held_q ? w_data_q : s_axi_wdata_i;
  assign wr_strb = w_held_q ? w_strb_q : s_axi_wstrb_i;
  assign wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_mapped = (wr_addr[1:0] == 2'h0);
  assign rd_mapped = (s_axi_araddr_i[1:0] == 2'h0);

  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `LSIF_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `LSIF_RESP_OKAY : `LSIF_RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr_i;
        end
        if (w_fire) begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata_i;
          w_strb_q <= s_axi_wstrb_i;
        end
        if (bvalid_q && s_axi_bready_i) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;

  // ---------------- decoded events ----------------
  wire cfg_rd;
  wire cfg_wr;
  wire low_wr;
  wire high_wr;
  wire [15:0] cfg_wr_val;
  wire cfg_wr_run;
  wire latch_now;
  wire eoc_now;
  wire latch_drop;
  wire alert_hit;

  // register reads have side effects only at the config offset
  assign cfg_rd = ar_fire && (s_axi_araddr_i == `LSIF_ADDR_CONFIG);
  assign cfg_wr = wr_go && (wr_addr == `LSIF_ADDR_CONFIG);
  assign low_wr = wr_go && (wr_addr == `LSIF_ADDR_LOW_LIMIT);
  assign high_wr = wr_go && (wr_addr == `LSIF_ADDR_HIGH_LIMIT);
  assign cfg_wr_val = (cfg_q & ~(`LSIF_CFG_WMASK & wr_mask)) |
                      (wr_data[15:0] & `LSIF_CFG_WMASK & wr_mask);
  assign cfg_wr_run = cfg_wr &&
    (cfg_wr_val[`LSIF_CFG_MODE_HI:`LSIF_CFG_MODE_LO] != `LSIF_MODE_SHUTDOWN);
  assign latch_now = cfg_q[`LSIF_CFG_LATCH_BIT];
  assign eoc_now = (low_q[15:14] == `LSIF_EOC_CODE);
  // latch 1 to 0 clears irq
  assign latch_drop = cfg_wr_run && latch_now && !cfg_wr_val[`LSIF_CFG_LATCH_BIT];
  assign alert_hit = alert_req_i && alert_won_i && latch_now;

  // ---------------- limit comparisons ----------------
  wire hi_cond;
  wire lo_cond;
  wire hi_fault;
  wire lo_fault;

  assign hi_cond = to_linear(conv_result_i) > to_linear(high_q);
  assign lo_cond = to_linear(conv_result_i) < to_linear(low_q);

  lsif_fault_counter #(
    .CNT_W(CNT_W)
  ) u_high_count (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .conv_done_i(conv_done_i),
    .cond_i(hi_cond),
    .fault_count_i(cfg_q[`LSIF_CFG_FC_HI:`LSIF_CFG_FC_LO]),
    .fault_o(hi_fault)
  );

  lsif_fault_counter #(
    .CNT_W(CNT_W)
  ) u_low_count (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .conv_done_i(conv_done_i),
    .cond_i(lo_cond),
    .fault_count_i(cfg_q[`LSIF_CFG_FC_HI:`LSIF_CFG_FC_LO]),
    .fault_o(lo_fault)
  );

  // ---------------- flag and irq next state ----------------
  // clears are applied first, so a conversion in the same cycle wins
  always @* begin
    cfg_d = cfg_q;
    low_d = low_q;
    high_d = high_q;
    over_d = over_q;
    under_d = under_q;
    ready_d = ready_q;
    active_d = active_q;
    if (cfg_wr) begin
      cfg_d = cfg_wr_val;
    end
    if (low_wr) begin
      low_d = (low_q & ~wr_mask) | (wr_data[15:0] & wr_mask);
    end
    if (high_wr) begin
      high_d = (high_q & ~wr_mask) | (wr_data[15:0] & wr_mask);
    end
    if (cfg_rd) begin
      ready_d = 1'b0;
      if (latch_now) begin
        over_d = 1'b0;
        under_d = 1'b0;
        active_d = 1'b0;
      end else if (eoc_now) begin
        active_d = 1'b0;
      end
    end
    if (cfg_wr_run) begin
      ready_d = 1'b0;
      if (!latch_now && eoc_now) begin
        active_d = 1'b0;
      end
      if (latch_drop) begin
        active_d = 1'b0;
      end
    end
    if (alert_hit) begin
      active_d = 1'b0;
    end
    if (conv_done_i) begin
      ready_d = 1'b1;
      if (eoc_now) begin
        active_d = 1'b1;
      end
    end
    if (latch_now) begin
      if (hi_fault) begin
        over_d = 1'b1;
        active_d = 1'b1;
      end
      if (lo_fault) begin
        under_d = 1'b1;
        active_d = 1'b1;
      end
    end else begin
      if (hi_fault) begin
        over_d = 1'b1;
        under_d = 1'b0;
        active_d = 1'b1;
      end
      if (lo_fault) begin
        under_d = 1'b1;
        over_d = 1'b0;
        active_d = eoc_now;
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cfg_q <= `LSIF_CFG_RESET;
      low_q <= `LSIF_LOW_RESET;
      high_q <= `LSIF_HIGH_RESET;
      result_q <= 16'h0000;
      over_q <= 1'b0;
      under_q <= 1'b0;
      ready_q <= 1'b0;
      active_q <= 1'b0;
      int_pin_q <= 1'b1;
      alert_ack_q <= 1'b0;
      alert_over_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      low_q <= low_d;
      high_q <= high_d;
      if (conv_done_i) begin
        result_q <= conv_result_i;
      end
      over_q <= over_d;
      under_q <= under_d;
      ready_q <= ready_d;
      active_q <= active_d;
      int_pin_q <= cfg_d[`LSIF_CFG_SENSE_BIT] ? active_d : !active_d;
      alert_ack_q <= alert_hit;
      // the over flag rides as the last address bit of the alert answer
      alert_over_q <= alert_hit ? over_q : alert_over_q;
    end
  end

  assign int_pin_o = int_pin_q;
  assign alert_ack_o = alert_ack_q;
  assign alert_over_flag_o = alert_over_q;

  // ---------------- read path ----------------
  reg [15:0] rd_word;

  always @* begin
    rd_word = 16'h0000;
    case (s_axi_araddr_i)
      `LSIF_ADDR_RESULT: begin
        rd_word = result_q;
      end
      `LSIF_ADDR_CONFIG: begin
        rd_word = cfg_q;
        rd_word[`LSIF_CFG_READY_BIT] = ready_q;
        rd_word[`LSIF_CFG_OVER_BIT] = over_q;
        rd_word[`LSIF_CFG_UNDER_BIT] = under_q;
      end
      `LSIF_ADDR_LOW_LIMIT: begin
        rd_word = low_q;
      end
      `LSIF_ADDR_HIGH_LIMIT: begin
        rd_word = high_q;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `LSIF_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= {16'h0000, rd_word};
        rresp_q <= rd_mapped ? `LSIF_RESP_OKAY : `LSIF_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

endmodule // lsif_top

`default_nettype wire

// ### verif/lsif_host_model.sv
// axi4-lite host model for the register port
`timescale 1ns/1ps
`default_nettype none
module lsif_host_model (
  // clock
  input wire logic clk_sys_i,
  // requests
  output logic [3:0] awaddr_o,
  output logic awvalid_o,
  output logic [31:0] wdata_o,
  output logic wvalid_o,
  output logic bready_o,
  output logic [3:0] araddr_o,
  output logic arvalid_o,
  output logic rready_o,
  // answers
  input wire logic awready_i,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // readies sampled at the falling edge to stay clear of update races
  // slow raises bready only once bvalid is seen, so the response must stand
  task automatic wr(input logic [3:0] a, input logic [15:0] v, output logic [1:0] rsp,
                    input logic slow = 1'b0);
    logic ta, tw, tb, tv;
    @(posedge clk_sys_i);
    awaddr_o <= a;
    wdata_o <= {16'h0000, v};
    {awvalid_o, wvalid_o} <= 2'h3;
    bready_o <= !slow;
    do begin
      @(negedge clk_sys_i);
      ta = awready_i;
      tw = wready_i;
      tv = bvalid_i;
      tb = bvalid_i && bready_o;
      rsp = bresp_i;
      @(posedge clk_sys_i);
      if (ta) awvalid_o <= 1'b0;
      if (tw) wvalid_o <= 1'b0;
      bready_o <= !tb && (!slow || tv);
    end while (!tb);
  endtask
  // slow holds rready low at first so read data must stand
  task automatic rd(input logic [3:0] a, input logic slow, output logic [31:0] v,
                    output logic [1:0] rsp);
    logic ta, tb, tr;
    @(posedge clk_sys_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= !slow;
    do begin
      @(negedge clk_sys_i);
      ta = arready_i;
      tr = rvalid_i;
      tb = rvalid_i && rready_o;
      v = rdata_i;
      rsp = rresp_i;
      @(posedge clk_sys_i);
      if (ta) arvalid_o <= 1'b0;
      rready_o <= !tb && (!slow || tr);
    end while (!tb);
  endtask
endmodule // lsif_host_model
`default_nettype wire

// ### verif/lsif_top_monitor.sv
// port assertions for the light sensor interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module lsif_top_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // register bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // events and pin
  input wire logic conv_done_i,
  input wire logic alert_req_i,
  input wire logic alert_won_i,
  input wire logic alert_ack_o,
  input wire logic int_pin_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  chk_reset_idle: assert property (disable iff (1'b0)
    !resetn_i |=> int_pin_o && !alert_ack_o && !s_axi_bvalid_o) else $error("reset state");
  chk_ack_cause: assert property (
    alert_ack_o |-> $past(alert_req_i && alert_won_i)) else $error("ack without won alert");
  chk_ack_pulse: assert property (
    alert_ack_o |=> !alert_ack_o) else $error("ack longer than one cycle");
  chk_pin_cause: assert property (
    !$stable(int_pin_o) |-> $past(conv_done_i || alert_req_i || s_axi_arvalid_i ||
    s_axi_wvalid_i || s_axi_awvalid_i)) else $error("pin moved without event");
  chk_b_hold: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  chk_b_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o |-> ##1 s_axi_bvalid_o) else $error("write response late");
  chk_r_hold: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  chk_r_answer: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read answer late");
  chk_r_upper: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000) else $error("upper read bits set");
endmodule // lsif_top_monitor
`default_nettype wire

// ### verif/lsif_top_tb.sv
// self-checking bench for the light sensor interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module lsif_top_tb;
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] low;
    logic [15:0] res;
    logic [2:0] fl;
    logic pin;
  } lsif_row_t;
  // flags are ready, over, under; pin level with sense 0
  lsif_row_t rows [7] = '{
    '{16'h0200, 16'h0010, 16'h0200, 3'h6, 1'b0},
    '{16'h0200, 16'h0010, 16'h0050, 3'h6, 1'b0},
    '{16'h0200, 16'h0010, 16'h0005, 3'h5, 1'b1},
    '{16'h0200, 16'hc000, 16'h0050, 3'h5, 1'b0},
    '{16'h0200, 16'hc000, 16'h0200, 3'h6, 1'b0},
    '{16'h0210, 16'hc000, 16'h0050, 3'h6, 1'b0},
    '{16'h0210, 16'hc000, 16'h0200, 3'h6, 1'b0}};
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic conv_done_i = 1'b0;
  logic [15:0] conv_result_i = 16'h0000;
  logic alert_req_i = 1'b0;
  logic alert_won_i = 1'b0;
  logic [3:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, rsp;
  logic alert_ack, alert_over, int_pin;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  lsif_top dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .conv_done_i(conv_done_i),
    .conv_result_i(conv_result_i), .alert_req_i(alert_req_i), .alert_won_i(alert_won_i),
    .alert_ack_o(alert_ack), .alert_over_flag_o(alert_over), .int_pin_o(int_pin));
  lsif_host_model host_u (.clk_sys_i(clk_sys_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .wdata_o(wdata), .wvalid_o(wvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .rready_o(rready), .awready_i(awready), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic pin(input logic e);
    @(negedge clk_sys_i);
    chk("int pin", {15'h0000, e}, {15'h0000, int_pin});
  endtask
  // one-cycle conversion or alert pulse, returns where its effect is settled
  task automatic pulse(input logic cv, input logic [15:0] r, input logic won);
    @(posedge clk_sys_i);
    conv_done_i <= cv;
    conv_result_i <= r;
    alert_req_i <= !cv;
    alert_won_i <= won;
    @(posedge clk_sys_i);
    conv_done_i <= 1'b0;
    alert_req_i <= 1'b0;
    @(negedge clk_sys_i);
  endtask
  task automatic rdcfg(input logic [2:0] e);
    host_u.rd(4'h4, 1'b0, d, rsp);
    chk("cfg flags", {13'h0000, e}, {13'h0000, d[7:5]});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    host_u.rd(4'h4, 1'b0, d, rsp);
    chk("cfg reset", 16'h0010, d[15:0]);
    host_u.wr(4'hc, 16'h0100, rsp);
    foreach (rows[i]) begin
      host_u.wr(4'h8, rows[i].low, rsp);
      host_u.wr(4'h4, rows[i].cfg, rsp);
      pulse(1'b1, rows[i].res, 1'b0);
      pin(rows[i].pin);
      rdcfg(rows[i].fl);
    end
    rdcfg(3'h0);
    pin(1'b1);
    $display("mode table done");
    // a high fault here so the alert answer carries a set over flag
    pulse(1'b1, 16'h0200, 1'b0);
    pulse(1'b0, 16'h0000, 1'b0);
    chk("ack lost", 16'h0000, {15'h0000, alert_ack});
    pin(1'b0);
    pulse(1'b0, 16'h0000, 1'b1);
    chk("ack won", 16'h0001, {15'h0000, alert_ack});
    pin(1'b1);
    chk("alert over", 16'h0001, {15'h0000, alert_over});
    pulse(1'b1, 16'h0050, 1'b0);
    host_u.wr(4'h8, 16'h0000, rsp);
    host_u.wr(4'h4, 16'h0200, rsp);
    pin(1'b1);
    $display("latched alert done");
    pulse(1'b1, 16'h0200, 1'b0);
    pulse(1'b0, 16'h0000, 1'b1);
    chk("ack transparent", 16'h0000, {15'h0000, alert_ack});
    pin(1'b0);
    host_u.wr(4'h4, 16'h0000, rsp);
    pin(1'b0);
    rdcfg(3'h6);
    host_u.wr(4'h4, 16'h0200, rsp);
    pulse(1'b1, 16'h0200, 1'b0);
    host_u.wr(4'h4, 16'h0200, rsp);
    rdcfg(3'h2);
    pin(1'b0);
    host_u.wr(4'h4, 16'h0208, rsp);
    pin(1'b1);
    host_u.wr(4'h8, 16'h0010, rsp);
    host_u.wr(4'h4, 16'h0209, rsp);
    pulse(1'b1, 16'h0005, 1'b0);
    pin(1'b1);
    pulse(1'b1, 16'h0005, 1'b0);
    pin(1'b0);
    $display("transparent done");
    host_u.wr(4'h5, 16'h0000, rsp, 1'b1);
    chk("bresp unaligned", 16'h0002, {14'h0000, rsp});
    host_u.rd(4'h0, 1'b1, d, rsp);
    chk("result", 16'h0005, d[15:0]);
    chk("rresp", 16'h0000, {14'h0000, rsp});
    $display("bus done");
    // mid-run reset with under flag, ready and an inverted pin all set
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    pin(1'b1);
    rdcfg(3'h0);
    $display("reset done");
    test_done();
  end
endmodule // lsif_top_tb
bind lsif_top lsif_top_monitor mon_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .conv_done_i(conv_done_i), .alert_req_i(alert_req_i), .alert_won_i(alert_won_i),
  .alert_ack_o(alert_ack_o), .int_pin_o(int_pin_o));
`default_nettype wire
